// File: adc_cal_consts.svh
/*
 * Offsets, fields, reset values and cycle counts of the controller.
 * Definitions only; included by bare name.
 */
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH

// ****
// timing, in master clock cycles
// ****
`define TRIG_MIN_CYC 4
`define SW_HALF_CYC 64
`define SELF_CAL_CYC 3145655
`define SYS_OFF_CYC 1052599
`define SYS_GAIN_CYC 1068813
`define OFF_REF_CYC 2117389
`define SETTLE_CYC 506880
`define WORD_CYC 1024

// ****
// register byte offsets
// ****
`define REG_STATUS 8'h00
`define REG_RESULT 8'h04
`define REG_ZERO 8'h08
`define REG_FULL 8'h0C
`define REG_CTRL 8'h10

// ****
// status fields
// ****
`define ST_BIT_READY 0
`define ST_BIT_CAL 1
`define ST_BIT_SETTLING 2
`define ST_BIT_POL 3
`define ST_BIT_MODE_LO 4
`define ST_BIT_SW 6

// ****
// control fields and reset values
// ****
`define CTRL_BIT_MEAS_EN 0
`define CTRL_RESET 1'h1
`define VREF_CODE_DEF 24'h200000

`endif

// File: adc_cal_pkg.sv
/*
 * Types shared by the calibration controller modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adc_cal_pkg;

    // ****
    // controller sequence states
    // ****
    typedef enum logic [2:0] {
        ST_RUN,
        ST_TRIG,
        ST_CAL,
        ST_LAUNCH,
        ST_CONV
    } cal_state_e;

    // ****
    // calibration kinds
    // ****
    typedef enum logic [1:0] {
        MODE_SELF,
        MODE_SYS_OFF,
        MODE_SYS_GAIN,
        MODE_OFF_REF
    } cal_mode_e;

endpackage

// File: div_if.sv
/*
 * Request/answer bundle between the controller and its divider.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps

interface div_if #(parameter int W = 43);
    logic start;
    logic [W-1:0] num;
    logic [W-1:0] den;
    logic busy;
    logic done;
    logic [W-1:0] quot;

    // controller side
    modport master (output start, output num, output den,
                    input busy, input done, input quot);
    // divider side
    modport slave (input start, input num, input den,
                   output busy, output done, output quot);
endinterface

// File: sync3.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pins; output moves once stages two and three agree.
 */
`timescale 1ns/100ps

module sync3 #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // pins in, filtered levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;

    // follow stage three once two and three agree
    always_comb begin
        q_nxt = ((~(s2_r ^ s3_r)) & s3_r) | ((s2_r ^ s3_r) & q_r);
    end

    // ****
    // stage registers
    // ****
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else if (ce) begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // sync3

// File: seq_divider.sv
/*
 * Sequential restoring divider, one quotient bit per cycle.
 * Assumes start is raised only while busy is low; den must be nonzero.
 */
`timescale 1ns/100ps

module seq_divider #(
    parameter int W = 43
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // request and answer
    div_if.slave d
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0] rem_r, rem_nxt, quo_r, quo_nxt, den_r, den_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt, done_r, done_nxt;
    logic [W:0] trial;

    // one shift-subtract step per cycle while busy
    always_comb begin
        rem_nxt = rem_r;
        quo_nxt = quo_r;
        den_nxt = den_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        trial = {rem_r, quo_r[W-1]};
        if (d.start && !busy_r) begin
            rem_nxt = '0;
            quo_nxt = d.num;
            den_nxt = d.den;
            cnt_nxt = CW'(W);
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (trial >= {1'b0, den_r}) begin
                rem_nxt = W'(trial - {1'b0, den_r});
                quo_nxt = {quo_r[W-2:0], 1'b1};
            end else begin
                rem_nxt = trial[W-1:0];
                quo_nxt = {quo_r[W-2:0], 1'b0};
            end
            cnt_nxt = cnt_r - 1'b1;
            if (cnt_r == CW'(1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    // ****
    // divider registers
    // ****
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rem_r <= '0;
            quo_r <= '0;
            den_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce) begin
            rem_r <= rem_nxt;
            quo_r <= quo_nxt;
            den_r <= den_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign d.busy = busy_r;
    assign d.done = done_r;
    assign d.quot = quo_r;
endmodule // seq_divider

// File: adc_cal_ctrl.sv
/*
 * Calibration start, sequencing, output coding and clamping of a
 * delta-sigma converter, with an Avalon-MM register slave.
 * Assumes ANALOG_INPUT is a signed word from modulator logic on CLK_SYS,
 * and that calibration pins come asynchronously from a controller.
 */
// Local design decisions: register access over Avalon-MM and the register addresses.
// What this block and its controller do
// R1: controller holds trigger high at least 4 cycles, then drops it.
// R2: both select pins are captured on the trigger's falling edge.
// R3: polarity pin level chooses bipolar or unipolar.
// R4: controller keeps polarity steady.
// R5: controller recalibrates after changing polarity.
// R6: data ready high from step start until finished.
// R7: controller waits for one step to finish before the next.
// R8: controller runs the offset step before the gain step.
// R9: self-calibration end drops data ready with an input word.
// R10: system step end drops data ready with zero- or full-scale code.
// R11: after system calibration, no words until settled.
// R12: input above full scale gives all ones.
// R13: input below zero (or minus full) scale gives all zeros.
// R14: unipolar code is slope times input minus offset, plus half LSB.
// R15: bipolar code adds half scale so the zero point reads midscale.
// R16: shared trigger drops on a falling clock edge.
// R17: rising sleep realigns sampling and output.
// R18: sampling switch changes side every 64 cycles.
// R19: self-calibration drops data ready once settled.
// R20: other modes drop data ready once the term is determined.
// R21: select pairs 00 self, 11 offset, 01 gain, 10 offset with reference.
// R22: each step counts its fixed cycle total.
`timescale 1ns/100ps
`include "adc_cal_consts.svh"

module adc_cal_ctrl import adc_cal_pkg::*; #(
    parameter int AIN_W = 24,
    parameter int RES_BITS = 16,
    parameter int SELF_CAL_CYC = `SELF_CAL_CYC,
    parameter int SYS_OFF_CYC = `SYS_OFF_CYC,
    parameter int SYS_GAIN_CYC = `SYS_GAIN_CYC,
    parameter int OFF_REF_CYC = `OFF_REF_CYC,
    parameter int SETTLE_CYC = `SETTLE_CYC,
    parameter logic [AIN_W-1:0] VREF_CODE = `VREF_CODE_DEF
) (
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic CE,
    // calibration pins
    input wire logic CAL_TRIGGER,
    input wire logic CAL_SELECT_1,
    input wire logic CAL_SELECT_2,
    input wire logic POLARITY_SELECT,
    input wire logic SLEEP,
    // modulator word
    input wire logic signed [AIN_W-1:0] ANALOG_INPUT,
    // converter outputs
    output logic DATA_READY_N,
    output logic [RES_BITS-1:0] DOUT,
    output logic SAMPLE_SW,
    // avalon-mm slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    localparam int NW = AIN_W + RES_BITS + 3;
    localparam int CNT_W = 22;
    localparam int SET_W = 20;
    localparam int WC_W = $clog2(`WORD_CYC);
    localparam logic [5:0] SW_LAST = 6'(`SW_HALF_CYC - 1);
    localparam logic [RES_BITS-1:0] HALF_CODE = RES_BITS'(1) << (RES_BITS - 1);

    // ****
    // pin synchronisers
    // ****
    logic [4:0] pins_s;
    logic trig_s, sel1_s, sel2_s, pol_s, sleep_s;

    sync3 #(.W(5)) u_sync (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .ce(CE),
        .d({SLEEP, POLARITY_SELECT, CAL_SELECT_2, CAL_SELECT_1, CAL_TRIGGER}),
        .q(pins_s)
    );
    assign {sleep_s, pol_s, sel2_s, sel1_s, trig_s} = pins_s;

    // ****
    // divider for the slope arithmetic
    // ****
    div_if #(.W(NW)) dv ();

    seq_divider #(.W(NW)) u_div (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .ce(CE),
        .d(dv.slave)
    );

    // ****
    // state
    // ****
    cal_state_e state_r, state_nxt;
    cal_mode_e mode_r, mode_nxt;
    logic [2:0] trig_cnt_r, trig_cnt_nxt;
    logic [CNT_W-1:0] cal_cnt_r, cal_cnt_nxt;
    logic [SET_W-1:0] settle_r, settle_nxt;
    logic [WC_W-1:0] word_cnt_r, word_cnt_nxt;
    logic [5:0] sw_cnt_r, sw_cnt_nxt;
    logic sw_r, sw_nxt, sleep_prev_r, sleep_prev_nxt;
    logic data_ready_n_n_r, data_ready_n_n_nxt, meas_en_r, meas_en_nxt;
    logic div_start_r, div_start_nxt;
    logic [RES_BITS-1:0] dout_r, dout_nxt;
    logic [AIN_W-1:0] zero_r, zero_nxt, full_r, full_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;

    // ****
    // transfer arithmetic
    // ****
    logic signed [AIN_W:0] diff, span;
    logic signed [NW-1:0] diff_x, span_x, num_s;
    logic [RES_BITS-1:0] quot_clamped, zero_code;
    logic [CNT_W-1:0] cal_last;
    logic [31:0] be_mask, status_w;
    logic sleep_rise, req;

    // numerator and clamp for the output word
    always_comb begin
        diff = $signed({ANALOG_INPUT[AIN_W-1], ANALOG_INPUT})
             - $signed({zero_r[AIN_W-1], zero_r});
        span = $signed({full_r[AIN_W-1], full_r}) - $signed({zero_r[AIN_W-1], zero_r});
        diff_x = NW'(diff);
        span_x = NW'(span);
        if (pol_s) begin
            num_s = (diff_x <<< (RES_BITS - 1)) + (span_x <<< (RES_BITS - 1))
                  + (span_x >>> 1); // R15
        end else begin
            num_s = (diff_x <<< RES_BITS) + (span_x >>> 1); // R14
        end
        if (|dv.quot[NW-1:RES_BITS]) begin
            quot_clamped = '1; // R12
        end else begin
            quot_clamped = dv.quot[RES_BITS-1:0];
        end
        zero_code = pol_s ? HALF_CODE : '0; // R3
        case (mode_r) // R22
            MODE_SELF: cal_last = CNT_W'(SELF_CAL_CYC - 1);
            MODE_SYS_OFF: cal_last = CNT_W'(SYS_OFF_CYC - 1);
            MODE_SYS_GAIN: cal_last = CNT_W'(SYS_GAIN_CYC - 1);
            MODE_OFF_REF: cal_last = CNT_W'(OFF_REF_CYC - 1);
            default: cal_last = CNT_W'(SELF_CAL_CYC - 1);
        endcase
        be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                   {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
        status_w = '0;
        status_w[`ST_BIT_READY] = ~data_ready_n_n_r;
        status_w[`ST_BIT_CAL] = (state_r == ST_TRIG) || (state_r == ST_CAL);
        status_w[`ST_BIT_SETTLING] = |settle_r;
        status_w[`ST_BIT_POL] = pol_s;
        status_w[`ST_BIT_MODE_LO +: 2] = mode_r;
        status_w[`ST_BIT_SW] = sw_r;
        sleep_rise = sleep_s && !sleep_prev_r;
        req = AVS_READ || AVS_WRITE;
    end

    assign dv.start = div_start_r;
    assign dv.num = num_s;
    assign dv.den = span_x;

    // ****
    // next state: bus, timing, calibration sequence
    // ****
    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        trig_cnt_nxt = trig_cnt_r;
        cal_cnt_nxt = cal_cnt_r;
        settle_nxt = settle_r;
        word_cnt_nxt = word_cnt_r;
        sw_cnt_nxt = sw_cnt_r;
        sw_nxt = sw_r;
        sleep_prev_nxt = sleep_prev_r;
        data_ready_n_n_nxt = data_ready_n_n_r;
        meas_en_nxt = meas_en_r;
        div_start_nxt = 1'b0;
        dout_nxt = dout_r;
        zero_nxt = zero_r;
        full_nxt = full_r;
        rdata_nxt = rdata_r;
        wait_nxt = wait_r;
        // bus slave: one wait state
        if (req && wait_r) begin
            wait_nxt = 1'b0;
            case (AVS_ADDRESS)
                `REG_STATUS: rdata_nxt = status_w;
                `REG_RESULT: rdata_nxt = 32'(dout_r);
                `REG_ZERO: rdata_nxt = 32'(signed'(zero_r));
                `REG_FULL: rdata_nxt = 32'(signed'(full_r));
                `REG_CTRL: rdata_nxt = 32'(meas_en_r);
                default: rdata_nxt = '0;
            endcase
        end else if (!wait_r) begin
            wait_nxt = 1'b1;
            if (AVS_WRITE) begin
                case (AVS_ADDRESS)
                    `REG_ZERO: zero_nxt = AIN_W'((32'(zero_r) & ~be_mask) | (AVS_WRITEDATA & be_mask));
                    `REG_FULL: full_nxt = AIN_W'((32'(full_r) & ~be_mask) | (AVS_WRITEDATA & be_mask));
                    `REG_CTRL: if (AVS_BYTEENABLE[0]) begin
                        meas_en_nxt = AVS_WRITEDATA[`CTRL_BIT_MEAS_EN];
                    end
                    default: ;
                endcase
            end
        end
        sleep_prev_nxt = sleep_s;
        // sampling switch and word timer, realigned by sleep
        if (sleep_rise) begin // R17
            sw_cnt_nxt = '0;
            sw_nxt = 1'b0;
            word_cnt_nxt = '0;
        end else begin
            sw_cnt_nxt = (sw_cnt_r == SW_LAST) ? 6'h00 : sw_cnt_r + 6'h01; // R18
            if (sw_cnt_r == SW_LAST) begin
                sw_nxt = ~sw_r; // R18
            end
            word_cnt_nxt = word_cnt_r + 1'b1;
        end
        if (settle_r != '0) begin
            settle_nxt = settle_r - 1'b1; // R11
        end
        // calibration and conversion sequence
        case (state_r)
            ST_RUN: begin
                if (trig_s) begin
                    state_nxt = ST_TRIG;
                    trig_cnt_nxt = 3'h1;
                    data_ready_n_n_nxt = 1'b1; // R6
                end else if (word_cnt_r == '1 && !sleep_rise && meas_en_r
                             && settle_r == '0) begin // R11
                    state_nxt = ST_LAUNCH;
                end
            end
            ST_TRIG: begin
                if (trig_s) begin
                    if (trig_cnt_r != 3'(`TRIG_MIN_CYC)) begin
                        trig_cnt_nxt = trig_cnt_r + 3'h1;
                    end
                end else if (trig_cnt_r == 3'(`TRIG_MIN_CYC)) begin // R1
                    case ({sel1_s, sel2_s}) // R2 R21
                        2'b00: mode_nxt = MODE_SELF;
                        2'b11: mode_nxt = MODE_SYS_OFF;
                        2'b01: mode_nxt = MODE_SYS_GAIN;
                        default: mode_nxt = MODE_OFF_REF;
                    endcase
                    cal_cnt_nxt = '0;
                    settle_nxt = '0;
                    state_nxt = ST_CAL;
                end else begin
                    state_nxt = ST_RUN;
                end
            end
            ST_CAL: begin
                if (trig_s) begin
                    state_nxt = ST_TRIG;
                    trig_cnt_nxt = 3'h1;
                end else if (cal_cnt_r != cal_last) begin
                    cal_cnt_nxt = cal_cnt_r + 1'b1; // R22
                end else begin
                    state_nxt = ST_RUN;
                    case (mode_r)
                        MODE_SELF: begin
                            zero_nxt = '0;
                            full_nxt = VREF_CODE;
                            state_nxt = ST_LAUNCH; // R19
                        end
                        MODE_SYS_OFF: begin
                            zero_nxt = ANALOG_INPUT;
                            dout_nxt = zero_code; // R10
                            data_ready_n_n_nxt = 1'b0; // R20
                        end
                        MODE_SYS_GAIN: begin
                            full_nxt = ANALOG_INPUT;
                            dout_nxt = '1; // R10
                            data_ready_n_n_nxt = 1'b0; // R20
                        end
                        default: begin
                            zero_nxt = ANALOG_INPUT;
                            full_nxt = VREF_CODE;
                            dout_nxt = zero_code; // R10
                            data_ready_n_n_nxt = 1'b0; // R20
                        end
                    endcase
                    if (mode_r != MODE_SELF) begin
                        settle_nxt = SET_W'(SETTLE_CYC); // R11
                    end
                end
            end
            ST_LAUNCH: begin
                if (trig_s) begin
                    state_nxt = ST_TRIG;
                    trig_cnt_nxt = 3'h1;
                    data_ready_n_n_nxt = 1'b1;
                end else if (span <= 0 || num_s < 0) begin
                    dout_nxt = '0; // R13
                    data_ready_n_n_nxt = 1'b0; // R9
                    state_nxt = ST_RUN;
                end else if (!dv.busy) begin
                    div_start_nxt = 1'b1;
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (trig_s) begin
                    state_nxt = ST_TRIG;
                    trig_cnt_nxt = 3'h1;
                    data_ready_n_n_nxt = 1'b1;
                end else if (dv.done) begin
                    dout_nxt = quot_clamped; // R12 R14 R15
                    data_ready_n_n_nxt = 1'b0; // R9
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // ****
    // registers
    // ****
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= ST_RUN;
            mode_r <= MODE_SELF;
            trig_cnt_r <= '0;
            cal_cnt_r <= '0;
            settle_r <= '0;
            word_cnt_r <= '0;
            sw_cnt_r <= '0;
            sw_r <= 1'b0;
            sleep_prev_r <= 1'b0;
            data_ready_n_n_r <= 1'b1;
            meas_en_r <= `CTRL_RESET;
            div_start_r <= 1'b0;
            dout_r <= '0;
            zero_r <= '0;
            full_r <= VREF_CODE;
            rdata_r <= '0;
            wait_r <= 1'b1;
        end else if (CE) begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            trig_cnt_r <= trig_cnt_nxt;
            cal_cnt_r <= cal_cnt_nxt;
            settle_r <= settle_nxt;
            word_cnt_r <= word_cnt_nxt;
            sw_cnt_r <= sw_cnt_nxt;
            sw_r <= sw_nxt;
            sleep_prev_r <= sleep_prev_nxt;
            data_ready_n_n_r <= data_ready_n_n_nxt;
            meas_en_r <= meas_en_nxt;
            div_start_r <= div_start_nxt;
            dout_r <= dout_nxt;
            zero_r <= zero_nxt;
            full_r <= full_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end

    assign DATA_READY_N = data_ready_n_n_r;
    assign DOUT = dout_r;
    assign SAMPLE_SW = sw_r;
    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
endmodule // adc_cal_ctrl

// File: adc_cal_ctrl_props.sv
/* port checker of the calibration controller.
   assumes one clock and the bind below. */
`timescale 1ns/100ps
module adc_cal_ctrl_props #(
    parameter int RES_BITS = 16,
    parameter int SELF_CAL_CYC = 60,
    parameter int SYS_OFF_CYC = 40
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // watched pins
    input wire logic CAL_TRIGGER,
    input wire logic DATA_READY_N,
    input wire logic [RES_BITS-1:0] DOUT,
    input wire logic SAMPLE_SW,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    logic [11:0] cal_cnt_r;
    logic [3:0] trig_lo_r;
    logic [7:0] sw_cnt_r;
    logic sw_q_r;
    logic seen_r;
    // cycle counters for the properties
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cal_cnt_r <= 12'hFFF;
            trig_lo_r <= 4'hF;
            sw_cnt_r <= 8'h00;
            sw_q_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            trig_lo_r <= CAL_TRIGGER ? 4'h0 : (trig_lo_r == 4'hF ? 4'hF : trig_lo_r + 4'h1);
            if (!CAL_TRIGGER && trig_lo_r == 4'h0) begin
                cal_cnt_r <= 12'h001;
            end else if (cal_cnt_r != 12'hFFF) begin
                cal_cnt_r <= cal_cnt_r + 12'h001;
            end
            sw_q_r <= SAMPLE_SW;
            if (SAMPLE_SW != sw_q_r) begin
                sw_cnt_r <= 8'h01;
                seen_r <= 1'b1;
            end else if (sw_cnt_r != 8'hFF) begin
                sw_cnt_r <= sw_cnt_r + 8'h01;
            end
        end
    end
    property p_ready_rise; $rose(CAL_TRIGGER) |-> ##[1:8] DATA_READY_N; endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready not raised");
    property p_ready_hold; $fell(CAL_TRIGGER) |-> ##6 DATA_READY_N [*8]; endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped early");
    property p_no_early; $fell(DATA_READY_N) |-> cal_cnt_r >= SYS_OFF_CYC; endproperty
    a_no_early: assert property (p_no_early) else $error("step shorter than count");
    property p_ready_bound; cal_cnt_r == SELF_CAL_CYC + 80 |-> !DATA_READY_N; endproperty
    a_ready_bound: assert property (p_ready_bound) else $error("step never ended");
    property p_sw_period; (SAMPLE_SW != sw_q_r) && seen_r |-> sw_cnt_r == 8'h40; endproperty
    a_sw_period: assert property (p_sw_period) else $error("switch period wrong");
    property p_dout_word; $changed(DOUT) |-> ##[0:2] !DATA_READY_N; endproperty
    a_dout_word: assert property (p_dout_word) else $error("word without ready");
    property p_ready_cause; $rose(DATA_READY_N) |-> trig_lo_r < 4'h8; endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready rose untriggered");
    property p_bus_wait; $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer late");
endmodule // adc_cal_ctrl_props

bind adc_cal_ctrl adc_cal_ctrl_props #(.RES_BITS(RES_BITS), .SELF_CAL_CYC(SELF_CAL_CYC),
    .SYS_OFF_CYC(SYS_OFF_CYC)) u_props (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
    .CAL_TRIGGER(CAL_TRIGGER), .DATA_READY_N(DATA_READY_N), .DOUT(DOUT),
    .SAMPLE_SW(SAMPLE_SW), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));

// File: adc_cal_host.sv
/* controller model driving the calibration pins.
   assumes the bench calls its tasks; sleep stays low. */
`timescale 1ns/100ps
`include "adc_cal_consts.svh"
module adc_cal_host (
    // master clock
    input wire logic clk,
    // calibration pins
    output logic cal_trigger,
    output logic cal_select_1,
    output logic cal_select_2,
    output logic polarity_select,
    output logic sleep
);
    // pins idle low
    initial begin
        cal_trigger = 1'b0;
        cal_select_1 = 1'b0;
        cal_select_2 = 1'b0;
        polarity_select = 1'b0;
        sleep = 1'b0;
    end
    // one step: selects, long trigger, release on falling edge
    task automatic step(input logic s1, input logic s2);
        @(posedge clk);
        cal_select_1 <= s1;
        cal_select_2 <= s2;
        cal_trigger <= 1'b1;
        repeat (`TRIG_MIN_CYC + 2) @(posedge clk);
        @(negedge clk);
        cal_trigger <= 1'b0;
    endtask
    // polarity moves only between steps, a step follows
    task automatic set_pol(input logic p);
        @(posedge clk);
        polarity_select <= p;
    endtask
endmodule // adc_cal_host

// File: adc_cal_ctrl_test.sv
/* self-checking bench of the calibration controller.
   assumes the host model and short step counts. */
`timescale 1ns/100ps
`include "adc_cal_consts.svh"
`define CHECK(g, e, m) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t %s", $time, m); end end
module adc_cal_ctrl_test;
    localparam int OFF = 40;
    localparam int GAIN = 50;
    localparam int REF = 70;
    localparam int SELF = 60;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic signed [23:0] analog_input = 24'h000000;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata, q;
    logic wreq, data_ready_n_n, sw, trig, s1, s2, pol, slp;
    logic [15:0] dout;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    // cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            summarize();
        end
    end
    adc_cal_host host (.clk(clk), .cal_trigger(trig), .cal_select_1(s1), .cal_select_2(s2),
        .polarity_select(pol), .sleep(slp));
    adc_cal_ctrl #(.SELF_CAL_CYC(SELF), .SYS_OFF_CYC(OFF), .SYS_GAIN_CYC(GAIN),
        .OFF_REF_CYC(REF), .SETTLE_CYC(50)) dut (.CLK_SYS(clk), .ARST_N(arst_n), .CE(1'b1),
        .CAL_TRIGGER(trig), .CAL_SELECT_1(s1), .CAL_SELECT_2(s2), .POLARITY_SELECT(pol),
        .SLEEP(slp), .ANALOG_INPUT(analog_input), .DATA_READY_N(data_ready_n_n), .DOUT(dout), .SAMPLE_SW(sw),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq));
    // counts and verdict
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // reset values, unmapped place, write and read back
    task automatic t_regs();
        bus(1'b0, `REG_CTRL, 32'h0);
        `CHECK(q, 32'h00000001, "ctrl reset")
        bus(1'b0, `REG_FULL, 32'h0);
        `CHECK(q, 32'h00200000, "full reset")
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        `CHECK(q, 32'h00000000, "unmapped read")
        $display("test regs done");
    endtask
    // one calibration step, length and word at its end
    task automatic t_step(input logic a, input logic b, input int lo, input int hi,
        input logic [15:0] e);
        int c;
        c = 0;
        host.step(a, b);
        @(posedge clk);
        `CHECK(data_ready_n_n, 1'b1, "ready low in step")
        while (data_ready_n_n !== 1'b0 && c < 4000) begin @(posedge clk); c++; end
        `CHECK((c >= lo && c <= hi), 1'b1, "step length")
        @(posedge clk);
        `CHECK(dout, e, "step word")
        $display("test step %b%b done", a, b);
    endtask
    // measurement word after two word periods
    task automatic t_word(input logic [23:0] a, input logic [15:0] e);
        analog_input <= a;
        repeat (2200) @(posedge clk);
        `CHECK(dout, e, "measured word")
        $display("test word %h done", a);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        analog_input <= 24'h001000;
        t_step(1'b1, 1'b1, OFF, OFF + 10, 16'h0000);
        analog_input <= 24'h011000;
        t_step(1'b0, 1'b1, GAIN, GAIN + 10, 16'hFFFF);
        analog_input <= 24'h000800;
        t_step(1'b1, 1'b0, REF, REF + 10, 16'h0000);
        analog_input <= 24'h100000;
        t_step(1'b0, 1'b0, SELF + 40, SELF + 70, 16'h8000);
        bus(1'b1, `REG_ZERO, 32'h00001000);
        bus(1'b1, `REG_FULL, 32'h00021000);
        t_word(24'h009001, 16'h4001);
        t_word(24'h030000, 16'hFFFF);
        t_word(24'h000800, 16'h0000);
        host.set_pol(1'b1);
        analog_input <= 24'h001000;
        t_step(1'b1, 1'b1, OFF, OFF + 10, 16'h8000);
        bus(1'b1, `REG_ZERO, 32'h00001000);
        bus(1'b1, `REG_FULL, 32'h00021000);
        t_word(24'h011000, 16'hC000);
        summarize();
    end
endmodule // adc_cal_ctrl_test
